/* File: dcbo_pkg.sv */
package dcbo_pkg;
   // Address layout: 32-byte line of eight 32-bit words
   localparam int DCBO_ADDR_W = 32;
   localparam int DCBO_BYTE_OFF_W = 2;
   localparam int DCBO_WORD_IDX_W = 3;
   localparam int DCBO_LINE_OFF_W = DCBO_BYTE_OFF_W + DCBO_WORD_IDX_W;
   localparam int DCBO_IDX_W = 4;
   localparam int DCBO_NUM_LINES = 16;
   localparam int DCBO_TAG_W = DCBO_ADDR_W - DCBO_IDX_W - DCBO_LINE_OFF_W;
   localparam int DCBO_WORDS = 8;

   // Extended opcodes (86, 470, 54, 278, 246, 1014)
   localparam logic [9:0] DCBO_XO_FLUSH = 10'h056;
   localparam logic [9:0] DCBO_XO_INVAL = 10'h1D6;
   localparam logic [9:0] DCBO_XO_STORE = 10'h036;
   localparam logic [9:0] DCBO_XO_TOUCH = 10'h116;
   localparam logic [9:0] DCBO_XO_TOUCHST = 10'h0F6;
   localparam logic [9:0] DCBO_XO_ZERO = 10'h3F6;

   // Base field value that selects a zero base
   localparam logic [4:0] DCBO_BASE_ZERO = 5'h00;
   // Value shown on the condition field
   localparam logic [3:0] DCBO_COND_VALUE = 4'h0;

   // Decoded block operation
   typedef enum logic [2:0] {
      OP_NONE, OP_FLUSH, OP_INVAL, OP_STORE, OP_TOUCH, OP_TOUCHST, OP_ZERO
   } dcbo_op_e;

   // Request from the pipeline with translation attributes
   typedef struct packed {
      logic [9:0] ext_opcode;
      logic [4:0] base_register_field;
      logic [31:0] base_value;
      logic [31:0] index_value;
      logic rc_bit;
      logic privileged;
      logic cacheable;
      logic write_through;
      logic xlate_fault;
   } dcbo_req_s;

   // Result of one operation
   typedef struct packed {
      logic [31:0] effective_address;
      logic align_exc;
      logic priv_exc;
      logic storage_exc;
      logic dsi_as_store;
      logic dac_as_store;
      logic [3:0] condition_field_zero;
   } dcbo_rsp_s;

   // One word transfer toward main storage
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } dcbo_mreq_s;

   // Line state held per cache entry
   typedef struct packed {
      logic valid;
      logic dirty;
      logic [DCBO_TAG_W-1:0] tag;
   } dcbo_meta_s;

   // Opcode decoder
   function automatic dcbo_op_e dcbo_decode(input logic [9:0] xo);
      dcbo_op_e op;
      op = OP_NONE;
      case (xo)
         DCBO_XO_FLUSH: op = OP_FLUSH;
         DCBO_XO_INVAL: op = OP_INVAL;
         DCBO_XO_STORE: op = OP_STORE;
         DCBO_XO_TOUCH: op = OP_TOUCH;
         DCBO_XO_TOUCHST: op = OP_TOUCHST;
         DCBO_XO_ZERO: op = OP_ZERO;
         default: op = OP_NONE;
      endcase
      return op;
   endfunction
endpackage

/* File: dcbo_ea_calc.sv */
`timescale 1ns/1ps
// Effective address adder, purely combinational
module dcbo_addr_calc (
   input wire logic [4:0] base_register_field,
   input wire logic [31:0] base_value,
   input wire logic [31:0] index_value,
   output logic [31:0] effective_address
);
   import dcbo_pkg::*;

   // Field value zero means a zero base, not register zero
   always_comb begin
      if (base_register_field == DCBO_BASE_ZERO) begin
         effective_address = index_value;
      end else begin
         effective_address = base_value + index_value;
      end
   end
endmodule // dcbo_addr_calc

/* File: dcbo_line_store.sv */
`timescale 1ns/1ps
// Direct-mapped line array: state and data in flip-flops
module dcbo_line_store #(
   parameter int NUM_LINES = dcbo_pkg::DCBO_NUM_LINES,
   parameter int WORDS = dcbo_pkg::DCBO_WORDS
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [dcbo_pkg::DCBO_IDX_W-1:0] index,
   input wire logic meta_we,
   input wire dcbo_pkg::dcbo_meta_s meta_in,
   input wire logic word_we,
   input wire logic [dcbo_pkg::DCBO_WORD_IDX_W-1:0] word_sel,
   input wire logic [31:0] word_in,
   input wire logic zero_all,
   input wire logic [dcbo_pkg::DCBO_WORD_IDX_W-1:0] rd_sel,
   output dcbo_pkg::dcbo_meta_s meta_out,
   output logic [31:0] word_out
);
   import dcbo_pkg::*;

   dcbo_meta_s meta_q [NUM_LINES]; // Valid, dirty, tag per line
   logic [31:0] data_q [NUM_LINES][WORDS]; // Line data, no reset needed

   // Read side sees the addressed line
   assign meta_out = meta_q[index];
   assign word_out = data_q[index][rd_sel];

   for (genvar g = 0; g < NUM_LINES; g++) begin : g_line
      // Line state, cleared so nothing looks valid after reset
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            meta_q[g] <= '0;
         end else if (meta_we && index == DCBO_IDX_W'(g)) begin
            meta_q[g] <= meta_in;
         end
      end

      // Data: whole-line zero wins over single word write
      always_ff @(posedge clk) begin
         if (zero_all && index == DCBO_IDX_W'(g)) begin
            for (int w = 0; w < WORDS; w++) begin
               data_q[g][w] <= 32'h00000000;
            end
         end else if (word_we && index == DCBO_IDX_W'(g)) begin
            data_q[g][word_sel] <= word_in;
         end
      end
   end
endmodule // dcbo_line_store

/* File: dcbo_block_ops.sv */
`timescale 1ns/1ps
module dcbo_block_ops (
   input wire logic clk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire dcbo_pkg::dcbo_req_s req,
   output logic req_ready,
   output logic rsp_done,
   output dcbo_pkg::dcbo_rsp_s rsp,
   output dcbo_pkg::dcbo_mreq_s mem_req,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata
);
   import dcbo_pkg::*;

   // Sequencer states
   typedef enum logic [2:0] {ST_IDLE, ST_LOOK, ST_WB, ST_FILL} dcbo_state_e;

   dcbo_state_e state; // Current state
   dcbo_state_e next_state; // State for next edge
   dcbo_req_s req_q; // Latched request
   dcbo_op_e op_q; // Latched decoded operation
   logic [31:0] eff_addr_comb; // Adder output
   logic [31:0] eff_addr_q; // Latched effective address
   logic [DCBO_IDX_W-1:0] idx_q; // Line index of the address
   logic [DCBO_TAG_W-1:0] tag_q; // Tag of the address
   logic [DCBO_TAG_W-1:0] xfer_tag; // Tag used on the memory side
   logic [DCBO_WORD_IDX_W-1:0] word_cnt; // Word within transfer
   logic [DCBO_WORD_IDX_W-1:0] rd_sel; // Data read select
   dcbo_meta_s look_meta; // State of the indexed line
   logic [31:0] look_word; // Data word of the indexed line
   dcbo_meta_s meta_in; // New line state
   logic meta_we; // Line state write
   logic word_we; // Fill word write
   logic zero_all; // Clear whole line
   logic hit; // Tag match on a valid line
   logic victim_dirty; // Indexed line is valid and dirty, whatever its tag
   logic is_touch; // Either touch form
   logic priv_fail; // Invalidate from user state
   logic align_fail; // Zero on unsuitable storage
   logic fault_fail; // Translation fault on a non-touch op
   logic eff_ok; // No exception, op may act
   logic touch_go; // Touch must bring the line in
   logic zero_go; // Zero may act
   logic wb_go; // A write-back must run first
   logic fill_go; // A fill starts straight away
   logic last_ack; // Final word of a transfer acknowledged

   // Address adder
   dcbo_addr_calc u_addr (
      .base_register_field(req.base_register_field),
      .base_value(req.base_value),
      .index_value(req.index_value),
      .effective_address(eff_addr_comb)
   );

   // Line array
   dcbo_line_store #(
      .NUM_LINES(DCBO_NUM_LINES),
      .WORDS(DCBO_WORDS)
   ) u_lines (
      .clk(clk),
      .resetn(resetn),
      .index(idx_q),
      .meta_we(meta_we),
      .meta_in(meta_in),
      .word_we(word_we),
      .word_sel(word_cnt),
      .word_in(mem_rdata),
      .zero_all(zero_all),
      .rd_sel(rd_sel),
      .meta_out(look_meta),
      .word_out(look_word)
   );

   // Lookup decisions, valid only in ST_LOOK
   always_comb begin
      hit = look_meta.valid && look_meta.tag == tag_q;
      victim_dirty = look_meta.valid && look_meta.dirty;
      is_touch = op_q == OP_TOUCH || op_q == OP_TOUCHST;
      priv_fail = op_q == OP_INVAL && !req_q.privileged;
      align_fail = op_q == OP_ZERO && (!req_q.cacheable || req_q.write_through);
      // Touch swallows faults silently
      fault_fail = req_q.xlate_fault && !is_touch;
      eff_ok = !priv_fail && !align_fail && !fault_fail;
      // Touch ignores hits, non-cacheable and faults
      touch_go = is_touch && !req_q.xlate_fault && req_q.cacheable && !hit;
      zero_go = op_q == OP_ZERO && eff_ok;
      // Flush and store-back never look at cacheability
      wb_go = eff_ok && (((op_q == OP_FLUSH || op_q == OP_STORE) && hit && look_meta.dirty)
              || ((touch_go || (zero_go && !hit)) && victim_dirty));
      fill_go = touch_go && !victim_dirty;
      last_ack = mem_ack && word_cnt == DCBO_WORD_IDX_W'(DCBO_WORDS - 1);
   end

   // Next data word is presented the cycle its predecessor is taken
   always_comb begin
      if (state == ST_WB && mem_ack) begin
         rd_sel = word_cnt + 1'b1;
      end else begin
         rd_sel = '0;
      end
   end

   // Line array updates
   always_comb begin
      meta_we = 1'b0;
      word_we = 1'b0;
      zero_all = 1'b0;
      meta_in = '{valid: 1'b0, dirty: 1'b0, tag: tag_q};
      case (state)
         ST_LOOK: begin
            if (eff_ok && op_q == OP_FLUSH && hit && !look_meta.dirty) begin
               meta_we = 1'b1;
            end else if (eff_ok && op_q == OP_INVAL && hit) begin
               meta_we = 1'b1;
            end else if (zero_go && (hit || !victim_dirty)) begin
               // Allocation without any read of main storage
               zero_all = 1'b1;
               meta_we = 1'b1;
               meta_in = '{valid: 1'b1, dirty: 1'b1, tag: tag_q};
            end
         end
         ST_WB: begin
            if (last_ack) begin
               meta_we = 1'b1;
               if (op_q == OP_STORE) begin
                  meta_in = '{valid: 1'b1, dirty: 1'b0, tag: tag_q};
               end else if (op_q == OP_ZERO) begin
                  zero_all = 1'b1;
                  meta_in = '{valid: 1'b1, dirty: 1'b1, tag: tag_q};
               end
               // Flush invalidates only now, after the last word left
               // Touch leaves the line invalid until its fill ends
            end
         end
         ST_FILL: begin
            word_we = mem_ack;
            if (last_ack) begin
               meta_we = 1'b1;
               meta_in = '{valid: 1'b1, dirty: 1'b0, tag: tag_q};
            end
         end
         default: begin
         end
      endcase
   end

   // State transitions
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (req_valid) begin
               next_state = ST_LOOK;
            end
         end
         ST_LOOK: begin
            if (wb_go) begin
               next_state = ST_WB;
            end else if (fill_go) begin
               next_state = ST_FILL;
            end else begin
               next_state = ST_IDLE;
            end
         end
         ST_WB: begin
            if (last_ack) begin
               next_state = is_touch ? ST_FILL : ST_IDLE;
            end
         end
         ST_FILL: begin
            if (last_ack) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Handshake flops; ready only while idle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_ready <= 1'b1;
         rsp_done <= 1'b0;
      end else begin
         req_ready <= next_state == ST_IDLE;
         rsp_done <= state != ST_IDLE && next_state == ST_IDLE;
      end
   end

   // Request capture; low address bits dropped for the line
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_q <= '0;
         op_q <= OP_NONE;
         eff_addr_q <= '0;
         idx_q <= '0;
         tag_q <= '0;
      end else if (state == ST_IDLE && req_valid) begin
         req_q <= req;
         op_q <= dcbo_decode(req.ext_opcode);
         eff_addr_q <= eff_addr_comb;
         idx_q <= eff_addr_comb[DCBO_LINE_OFF_W +: DCBO_IDX_W];
         tag_q <= eff_addr_comb[DCBO_ADDR_W-1 -: DCBO_TAG_W];
      end
   end

   // Result flops, written once per operation at lookup
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rsp <= '0;
      end else if (state == ST_LOOK) begin
         rsp.effective_address <= eff_addr_q;
         // One exception at a time, privilege first
         rsp.priv_exc <= priv_fail;
         rsp.align_exc <= !priv_fail && align_fail;
         rsp.storage_exc <= !priv_fail && !align_fail && fault_fail;
         rsp.dsi_as_store <= op_q == OP_INVAL || op_q == OP_ZERO;
         rsp.dac_as_store <= op_q != OP_NONE && !is_touch;
         // Field is undefined by definition; a fixed value is shown
         rsp.condition_field_zero <= DCBO_COND_VALUE;
      end
   end

   // Word counter and memory-side tag
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         word_cnt <= '0;
         xfer_tag <= '0;
      end else if (state == ST_LOOK) begin
         word_cnt <= '0;
         // Victim tag for evictions, own tag for hits
         xfer_tag <= wb_go ? look_meta.tag : tag_q;
      end else if (mem_ack) begin
         word_cnt <= word_cnt + 1'b1;
         if (last_ack) begin
            xfer_tag <= tag_q;
         end
      end
   end

   // Memory request, one word per acknowledge, line aligned
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mem_req <= '0;
      end else if (state == ST_LOOK && (wb_go || fill_go)) begin
         mem_req.valid <= 1'b1;
         mem_req.write <= wb_go;
         mem_req.addr <= {(wb_go ? look_meta.tag : tag_q), idx_q, DCBO_LINE_OFF_W'(0)};
         mem_req.wdata <= look_word;
      end else if (last_ack && state == ST_WB && is_touch) begin
         // Eviction done, the touch fill follows at once
         mem_req.valid <= 1'b1;
         mem_req.write <= 1'b0;
         mem_req.addr <= {tag_q, idx_q, DCBO_LINE_OFF_W'(0)};
         mem_req.wdata <= '0;
      end else if (last_ack) begin
         mem_req <= '0;
      end else if (mem_ack) begin
         mem_req.addr <= {xfer_tag, idx_q, word_cnt + 1'b1, DCBO_BYTE_OFF_W'(0)};
         mem_req.wdata <= look_word;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   a_addr_form:
   assert property ((state == ST_IDLE && req_valid) |=> eff_addr_q == (($past(req.base_register_field) == 5'h00)
      ? 32'h00000000 : $past(req.base_value)) + $past(req.index_value))
      else $error("effective address wrong");

   a_flush_wb_first:
   assert property ((state == ST_LOOK && op_q == OP_FLUSH && eff_ok && hit && look_meta.dirty)
      |=> mem_req.valid && mem_req.write && look_meta.valid)
      else $error("flush did not write back before invalidate");

   a_flush_clean:
   assert property ((state == ST_LOOK && op_q == OP_FLUSH && eff_ok && hit && !look_meta.dirty)
      |=> !mem_req.valid && !look_meta.valid && rsp_done)
      else $error("clean flush wrong");

   a_inval_priv:
   assert property ((state == ST_LOOK && op_q == OP_INVAL && !req_q.privileged)
      |=> rsp_done && rsp.priv_exc && $stable(look_meta))
      else $error("user invalidate not refused");

   a_inval_drop:
   assert property ((state == ST_LOOK && op_q == OP_INVAL && eff_ok && hit)
      |=> !look_meta.valid && !mem_req.valid)
      else $error("invalidate kept line or wrote back");

   a_store_keep:
   assert property ((state == ST_WB && op_q == OP_STORE && last_ack)
      |=> look_meta.valid && !look_meta.dirty && rsp_done)
      else $error("store-back did not leave clean valid line");

   a_touch_noop:
   assert property ((state == ST_LOOK && is_touch && (!req_q.cacheable || hit))
      |=> rsp_done && !mem_req.valid)
      else $error("touch acted when it should not");

   a_touch_no_exc:
   assert property ((state == ST_LOOK && is_touch && req_q.xlate_fault)
      |=> !rsp.storage_exc && !mem_req.valid)
      else $error("touch raised a fault");

   a_zero_align:
   assert property ((state == ST_LOOK && op_q == OP_ZERO && (!req_q.cacheable || req_q.write_through))
      |=> rsp.align_exc && rsp_done && $stable(look_meta))
      else $error("zero alignment case wrong");

   a_zero_line:
   assert property ((state == ST_LOOK && zero_go && (hit || !victim_dirty))
      |=> look_word == 32'h00000000 && look_meta.valid && look_meta.dirty)
      else $error("zero did not clear line");

   a_zero_noread:
   assert property ((mem_req.valid && !mem_req.write) |-> is_touch)
      else $error("read issued for a non-touch op");

   a_class_map:
   assert property (rsp_done |-> rsp.dsi_as_store == (op_q == OP_INVAL || op_q == OP_ZERO)
      && rsp.dac_as_store == (op_q != OP_NONE && !is_touch))
      else $error("exception class wrong");

   a_line_align:
   assert property ($rose(mem_req.valid) |-> mem_req.addr[4:0] == 5'h00)
      else $error("transfer not line aligned");
endmodule // dcbo_block_ops

/* File: dcbo_mem_model.sv */
`timescale 1ns/1ps
// Main storage behind the core memory bus, one word per ack
module dcbo_mem_model (
   input wire logic clk,
   input wire logic resetn,
   input wire dcbo_pkg::dcbo_mreq_s mem_req,
   input wire logic slow,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   import dcbo_pkg::*;
   int stall; // Cycles left before the next ack
   // Ack pulses one cycle; stalls only when slow is set
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0000_0000;
      stall = 0;
   end
   always @(posedge clk) begin
      #1;
      // Data is junk outside the ack cycle, toggled so nothing leans on it
      mem_rdata = ~mem_rdata;
      if (mem_ack) begin
         mem_ack = 1'b0;
         stall = slow ? int'($urandom_range(3)) : 0;
      end else if (resetn && mem_req.valid) begin
         if (stall == 0) begin
            mem_ack = 1'b1;
            mem_rdata = mem_req.addr ^ 32'h5A5A_0000;
         end else begin
            stall--;
         end
      end
   end
endmodule // dcbo_mem_model

/* File: dcbo_block_ops_test.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
   $display("unexpected at %0t: got %0h expected %0h", $time, a, b); end end
// Self-checking bench for the block operations
module dcbo_block_ops_test;
   import dcbo_pkg::*;
   typedef struct packed {
      logic [31:0] eff, wb; // wb: line base that write-backs must use
      logic al, pr, st, ds, dc;
      logic [3:0] wr, rd;
   } dcbo_note_s; // Expected outcome of one request
   logic clk, resetn, req_valid, req_ready, rsp_done, mem_ack, slow;
   dcbo_req_s req;
   dcbo_rsp_s rsp;
   dcbo_mreq_s mem_req;
   logic [31:0] mem_rdata, line; // line: current line base under test
   logic [31:0] victim; // Line left in the cache by the previous request
   logic [31:0] xfer_base; // Expected base of the transfer being acked
   int n_mismatch, cmp_count, n_wr, n_rd;
   dcbo_note_s exp_q[$];
   dcbo_block_ops i_dut (.clk(clk), .resetn(resetn), .req_valid(req_valid), .req(req),
      .req_ready(req_ready), .rsp_done(rsp_done), .rsp(rsp), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   dcbo_mem_model i_mem (.clk(clk), .resetn(resetn), .mem_req(mem_req), .slow(slow),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // 10 MHz core clock
   always #50 clk = ~clk;
   // Verdict, reached from the main flow or a stuck wait
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Bounded wait for the idle handshake
   task automatic wait_ready();
      int i;
      for (i = 0; i < 200 && req_ready !== 1'b1; i++) @(posedge clk) #1;
      if (i == 200) begin
         n_mismatch++;
         end_sim();
      end
   endtask
   // One request; offset within line and base/index split are random
   task automatic do_op(input logic [9:0] xo, input logic pv, ca, wt, xf,
                        input logic [3:0] wr, rd, input logic al, pr, st);
      dcbo_note_s n;
      logic [31:0] eff;
      eff = line | 32'($urandom_range(31));
      wait_ready();
      req.ext_opcode = xo;
      req.base_register_field = 5'($urandom_range(1));
      req.base_value = $urandom;
      // Zero field must ignore whatever the base holds
      req.index_value = (req.base_register_field == DCBO_BASE_ZERO) ? eff : eff - req.base_value;
      if (req.base_register_field != DCBO_BASE_ZERO) req.base_register_field = 5'($urandom_range(31, 1));
      req.rc_bit = 1'($urandom);
      req.privileged = pv;
      req.cacheable = ca;
      req.write_through = wt;
      req.xlate_fault = xf;
      n.eff = eff;
      // A miss onto a dirty line must write that older line back
      n.wb = victim;
      victim = line;
      n.al = al;
      n.pr = pr;
      n.st = st;
      n.ds = (xo == DCBO_XO_INVAL || xo == DCBO_XO_ZERO);
      n.dc = n.ds || xo == DCBO_XO_FLUSH || xo == DCBO_XO_STORE;
      n.wr = wr;
      n.rd = rd;
      exp_q.push_back(n);
      req_valid = 1'b1;
      @(posedge clk) #1;
      req_valid = 1'b0;
      wait_ready();
   endtask
   // Memory traffic and completion watcher
   always @(posedge clk) begin
      if (resetn && mem_req.valid && mem_ack && exp_q.size() > 0) begin
         xfer_base = mem_req.write ? exp_q[0].wb : {exp_q[0].eff[31:5], 5'h00};
         `CHK(mem_req.addr, xfer_base + 32'(4 * (mem_req.write ? n_wr : n_rd)))
         if (mem_req.write) begin
            `CHK(mem_req.wdata, 32'h0000_0000)
            n_wr++;
         end else n_rd++;
      end
      if (resetn && rsp_done) begin
         if (exp_q.size() == 0) begin
            n_mismatch++;
            $display("unexpected at %0t: got %0h expected %0h", $time, 1, 0);
         end else begin
            dcbo_note_s n;
            n = exp_q.pop_front();
            `CHK(rsp.effective_address, n.eff)
            `CHK(rsp.align_exc, n.al)
            `CHK(rsp.priv_exc, n.pr)
            `CHK(rsp.storage_exc, n.st)
            `CHK(rsp.dsi_as_store, n.ds)
            `CHK(rsp.dac_as_store, n.dc)
            `CHK(rsp.condition_field_zero, DCBO_COND_VALUE)
            `CHK(n_wr, int'(n.wr))
            `CHK(n_rd, int'(n.rd))
         end
         n_wr = 0;
         n_rd = 0;
      end
   end
   // Main flow: each pass picks a fresh line and latency mode
   initial begin
      clk = 1'b0;
      resetn = 1'b0;
      req_valid = 1'b0;
      req = '0;
      slow = 1'b0;
      line = 32'h0000_0000;
      n_mismatch = 0;
      cmp_count = 0;
      n_wr = 0;
      n_rd = 0;
      void'($urandom(22542));
      repeat (12) @(posedge clk);
      #1 resetn = 1'b1;
      for (int p = 0; p < 4; p++) begin
         line = $urandom & 32'hFFFF_FFE0;
         victim = line;
         slow = p[0];
         do_op(DCBO_XO_ZERO, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_STORE, 1, 0, 0, 0, 8, 0, 0, 0, 0);
         do_op(DCBO_XO_STORE, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         $display("test store_back done");
         do_op(DCBO_XO_ZERO, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_INVAL, 0, 1, 0, 0, 0, 0, 0, 1, 0);
         do_op(DCBO_XO_INVAL, 1, 0, 0, 0, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_FLUSH, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         $display("test invalidate done");
         do_op(DCBO_XO_TOUCH, 1, 0, 0, 0, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_TOUCH, 1, 1, 0, 1, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_TOUCHST, 1, 1, 0, 1, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_TOUCHST, 1, 1, 0, 0, 0, 8, 0, 0, 0);
         do_op(DCBO_XO_TOUCH, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_FLUSH, 1, 0, 0, 0, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_TOUCH, 1, 1, 0, 0, 0, 8, 0, 0, 0);
         $display("test touch done");
         do_op(DCBO_XO_ZERO, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_FLUSH, 1, 0, 0, 0, 8, 0, 0, 0, 0);
         do_op(DCBO_XO_FLUSH, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         $display("test zero_flush done");
         do_op(DCBO_XO_ZERO, 1, 1, 1, 0, 0, 0, 1, 0, 0);
         do_op(DCBO_XO_ZERO, 1, 0, 0, 0, 0, 0, 1, 0, 0);
         do_op(DCBO_XO_FLUSH, 1, 1, 0, 1, 0, 0, 0, 0, 1);
         do_op(10'h000, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         do_op(DCBO_XO_FLUSH, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         $display("test faults done");
         // Same index, other tag: each miss must evict the dirty line first
         do_op(DCBO_XO_ZERO, 1, 1, 0, 0, 0, 0, 0, 0, 0);
         line = line ^ 32'h0000_0200;
         do_op(DCBO_XO_ZERO, 1, 1, 0, 0, 8, 0, 0, 0, 0);
         line = line ^ 32'h0000_0200;
         do_op(DCBO_XO_TOUCH, 1, 1, 0, 0, 8, 8, 0, 0, 0);
         do_op(DCBO_XO_FLUSH, 1, 0, 0, 0, 0, 0, 0, 0, 0);
         $display("test victim done");
      end
      repeat (4) @(posedge clk);
      if (exp_q.size() != 0) n_mismatch++;
      end_sim();
   end
endmodule // dcbo_block_ops_test
